// file: core/hpx_ctrl.sv
// Plug detect pass-through, standby timer, AUX/DDC routing and link enable.
// Assumes pin inputs are asynchronous; local host settings come as plain ports.
`timescale 1ns/100ps
`include "hpx_regs.svh"

module hpx_ctrl #(
	parameter int STANDBY_CYC = `HPX_STANDBY_CYC
) (
	// Clock and reset
	input  wire logic               sys_clk_i,
	input  wire logic               sys_rst_i,
	// Pins
	input  wire logic               chip_reset_n_i,
	input  wire logic               sink_plug_detect_in_i,
	input  wire logic               sink_adapter_detect_in_i,
	output logic                    source_plug_detect_out_o,
	output logic                    source_adapter_detect_out_o,
	// Local host settings
	input  wire logic [1:0]         route_sel_i,
	input  wire logic               host_force_i,
	input  wire logic               host_plug_i,
	input  wire logic               host_adapter_i,
	input  wire logic               host_link_valid_i,
	input  wire hpx_pkg::hpx_link_t host_link_i,
	input  wire logic               host_drive_override_i,
	input  wire logic               training_done_i,
	// Status and control outputs
	output hpx_pkg::hpx_route_t     route_o,
	output hpx_pkg::hpx_link_t      link_o,
	output logic                    link_on_o,
	output logic                    shutdown_o,
	output logic                    standby_o,
	output logic                    tmds_mode_o
);
	localparam int CW = $clog2(STANDBY_CYC + 1);

	// Two-stage synchronisers for async pins
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic [2:0] pins;
	assign pins = {chip_reset_n_i, sink_plug_detect_in_i, sink_adapter_detect_in_i};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk_i)
			begin
				if (sys_rst_i)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= pins[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	logic rst_n_s;
	logic plug_s;
	logic adapt_s;
	assign rst_n_s = sync2_reg[2];
	assign plug_s  = sync2_reg[1];
	assign adapt_s = sync2_reg[0];

	// Effective detect levels; host force bypasses the pins
	logic plug_eff;
	logic adapt_eff;
	assign plug_eff  = host_force_i ? host_plug_i : plug_s;
	assign adapt_eff = host_force_i ? host_adapter_i : adapt_s;

	// Low timer; short interrupt pulses never reach the standby count
	logic [CW-1:0] low_cnt_reg;
	logic [CW-1:0] low_cnt_next;

	always_comb
	begin
		low_cnt_next = low_cnt_reg;
		if (plug_eff)
			low_cnt_next = '0;
		else if (low_cnt_reg != CW'(STANDBY_CYC))
			low_cnt_next = low_cnt_reg + CW'(1);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			low_cnt_reg <= '0;
		else
			low_cnt_reg <= low_cnt_next;
	end

	// Operating state; standby only after a full shut-off span
	hpx_pkg::hpx_state_t state_reg;
	hpx_pkg::hpx_state_t state_next;
	logic                powered;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			hpx_pkg::HPX_ST_OFF:
			begin
				if (rst_n_s)
					state_next = hpx_pkg::HPX_ST_ACTIVE;
			end
			hpx_pkg::HPX_ST_ACTIVE:
			begin
				if (!plug_eff && low_cnt_reg == CW'(STANDBY_CYC))
					state_next = hpx_pkg::HPX_ST_STANDBY;
			end
			hpx_pkg::HPX_ST_STANDBY:
			begin
				if (plug_eff)
					state_next = hpx_pkg::HPX_ST_ACTIVE;
			end
			default:
			begin
				state_next = hpx_pkg::HPX_ST_OFF;
			end
		endcase
		// Chip reset wins over every other transition
		if (!rst_n_s)
			state_next = hpx_pkg::HPX_ST_OFF;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			state_reg <= hpx_pkg::HPX_ST_OFF;
		else
			state_reg <= state_next;
	end

	assign powered = (state_reg != hpx_pkg::HPX_ST_OFF);

	// Detect pass-through; interrupt pulses ride along unfiltered
	logic plug_out_reg;
	logic plug_out_next;
	logic adapt_out_reg;
	logic adapt_out_next;
	logic tmds_reg;
	logic tmds_next;

	always_comb
	begin
		plug_out_next  = plug_eff;
		adapt_out_next = adapt_eff;
		tmds_next      = plug_eff && adapt_eff;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			plug_out_reg  <= 1'b0;
			adapt_out_reg <= 1'b0;
			tmds_reg      <= 1'b0;
		end
		else
		begin
			plug_out_reg  <= plug_out_next;
			adapt_out_reg <= adapt_out_next;
			tmds_reg      <= tmds_next;
		end
	end

	// Link enable and configuration; enable stays dark until programmed or trained
	logic               link_on_reg;
	logic               link_on_next;
	hpx_pkg::hpx_link_t link_reg;
	hpx_pkg::hpx_link_t link_next;

	always_comb
	begin
		link_on_next = link_on_reg;
		link_next    = link_reg;
		if (!powered)
		begin
			link_on_next = 1'b0;
			link_next    = '0;
		end
		else
		begin
			if (host_link_valid_i || training_done_i)
				link_on_next = 1'b1;
			if (adapt_eff && plug_eff)
			begin
				link_next.training_en = 1'b0;
				link_next.swing_mvpp  = `HPX_TMDS_SWING_MVPP;
				link_next.preemph_db  = `HPX_TMDS_PREEMPH_DB;
				link_next.lane_en     = `HPX_LANES_ALL;
				if (host_drive_override_i)
				begin
					link_next.swing_mvpp = host_link_i.swing_mvpp;
					link_next.preemph_db = host_link_i.preemph_db;
				end
			end
			else if (host_link_valid_i)
			begin
				link_next = host_link_i;
			end
			else
			begin
				link_next.training_en = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			link_on_reg <= 1'b0;
			link_reg    <= '0;
		end
		else
		begin
			link_on_reg <= link_on_next;
			link_reg    <= link_next;
		end
	end

	// Routing follows the detect inputs from power-up onward
	hpx_pkg::hpx_route_t route_reg;
	hpx_pkg::hpx_route_t route_next;

	always_comb
	begin
		route_next               = '0;
		route_next.ddc_pullup_on = adapt_eff;
		if (plug_eff && powered)
		begin
			route_next.sink_aux_on = 1'b1;
			if (!adapt_eff)
			begin
				// Select 11 is undefined; it falls back to the pass-through path
				if (route_sel_i == 2'b01)
					route_next.source_aux_on = 1'b0;
				else
					route_next.source_aux_on = 1'b1;
				route_next.monitor_on = 1'b1;
			end
			else if (route_sel_i[0] || route_sel_i[1])
			begin
				route_next.source_aux_on = 1'b1;
			end
			else
			begin
				route_next.ddc_on = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			route_reg <= '0;
		else
			route_reg <= route_next;
	end

	// Data outputs from flip-flops; shutdown and standby decoded from state_reg
	assign source_plug_detect_out_o    = plug_out_reg;
	assign source_adapter_detect_out_o = adapt_out_reg;
	assign route_o     = route_reg;
	assign link_o      = link_reg;
	assign link_on_o   = link_on_reg;
	assign shutdown_o  = !powered;
	assign standby_o   = (state_reg == hpx_pkg::HPX_ST_STANDBY);
	assign tmds_mode_o = tmds_reg;
endmodule // hpx_ctrl

// file: core/hpx_pkg.sv
// Types shared by the plug detect and routing control block.
// Assumes the constants header is included where counts are needed.
package hpx_pkg;
	typedef enum logic [1:0] {
		HPX_ST_OFF     = 2'b00,
		HPX_ST_ACTIVE  = 2'b01,
		HPX_ST_STANDBY = 2'b10
	} hpx_state_t;

	typedef struct packed {
		logic sink_aux_on;
		logic source_aux_on;
		logic ddc_on;
		logic monitor_on;
		logic ddc_pullup_on;
	} hpx_route_t;

	typedef struct packed {
		logic [9:0] swing_mvpp;
		logic [3:0] preemph_db;
		logic [3:0] lane_en;
		logic       training_en;
	} hpx_link_t;
endpackage

// file: core/hpx_regs.svh
// Timing counts and TMDS link drive values for the plug detect and routing control block.
// Assumes a 100 MHz system clock.
`ifndef HPX_REGS_SVH
`define HPX_REGS_SVH
`define HPX_CLK_MHZ          100
`define HPX_IRQ_MIN_US       500
`define HPX_IRQ_MAX_US       1000
`define HPX_STANDBY_MS       400
`define HPX_IRQ_MAX_CYC      (`HPX_IRQ_MAX_US * `HPX_CLK_MHZ)
`define HPX_STANDBY_CYC      (`HPX_STANDBY_MS * 1000 * `HPX_CLK_MHZ)
`define HPX_TMDS_SWING_MVPP  10'h258
`define HPX_TMDS_PREEMPH_DB  4'h0
`define HPX_LANES_ALL        4'hf
`endif

// file: sim/hpx_ctrl_checker.sv
// Assertions on the ports of the plug detect and routing control block.
// Assumes it is bound to hpx_ctrl and shares its one clock.
`timescale 1ns/100ps
module hpx_ctrl_checker #(
	parameter int STANDBY_CYC = 40000000
) (
	input wire logic                sys_clk_i,
	input wire logic                sys_rst_i,
	input wire logic                chip_reset_n_i,
	input wire logic                sink_plug_detect_in_i,
	input wire logic                sink_adapter_detect_in_i,
	input wire logic                source_plug_detect_out_o,
	input wire logic                source_adapter_detect_out_o,
	input wire logic [1:0]          route_sel_i,
	input wire logic                host_force_i,
	input wire logic                host_plug_i,
	input wire logic                host_adapter_i,
	input wire logic                host_drive_override_i,
	input wire hpx_pkg::hpx_route_t route_o,
	input wire hpx_pkg::hpx_link_t  link_o,
	input wire logic                shutdown_o,
	input wire logic                standby_o,
	input wire logic                tmds_mode_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Counts from the pin, so it runs ahead of the synced count
	logic [31:0] cnt_reg, cnt_next;
	always_comb cnt_next = (sys_rst_i || sink_plug_detect_in_i || host_force_i) ? '0 : cnt_reg + 1;
	always_ff @(posedge sys_clk_i) cnt_reg <= cnt_next;
	sequence s_st;
		(!host_force_i && chip_reset_n_i && !shutdown_o && !standby_o && $stable(route_sel_i)
		&& $stable(sink_plug_detect_in_i) && $stable(sink_adapter_detect_in_i))[*4];
	endsequence
	property p_rt(logic [1:0] s, logic c, logic [4:0] e);
		s_st ##0 (sink_plug_detect_in_i && route_sel_i == s && sink_adapter_detect_in_i == c)
		|-> route_o == e;
	endproperty
	a_reset_shutdown: assert property (!chip_reset_n_i [*6] |-> shutdown_o)
		else $error("no shutdown");
	a_plug_follow: assert property (s_st |-> source_plug_detect_out_o == sink_plug_detect_in_i
		&& (!sink_plug_detect_in_i || source_adapter_detect_out_o == sink_adapter_detect_in_i))
		else $error("plug copy wrong");
	a_host_force: assert property ((host_force_i && chip_reset_n_i && !shutdown_o
		&& $stable(host_plug_i) && $stable(host_adapter_i))[*4]
		|-> source_plug_detect_out_o == host_plug_i && source_adapter_detect_out_o == host_adapter_i)
		else $error("force ignored");
	a_route_off: assert property ((!host_force_i && !sink_plug_detect_in_i)[*4]
		|-> route_o[4:1] == 4'h0) else $error("paths on without sink");
	a_route_dp: assert property (p_rt(2'h0, 1'h0, 5'h1a)) else $error("dp route");
	a_route_tmds: assert property (p_rt(2'h0, 1'h1, 5'h15)) else $error("tmds route");
	a_route_mon: assert property (p_rt(2'h1, 1'h0, 5'h12)) else $error("monitor route");
	a_route_short: assert property (p_rt(2'h1, 1'h1, 5'h19)) else $error("short route");
	a_route_back: assert property (p_rt(2'h2, 1'h1, 5'h19)) else $error("back route");
	a_tmds_link: assert property ((tmds_mode_o && !host_drive_override_i && !shutdown_o)[*3]
		|-> link_o.lane_en == 4'hf && link_o.swing_mvpp == 10'h258
		&& link_o.preemph_db == 4'h0 && !link_o.training_en) else $error("tmds link");
	a_standby_min: assert property ($rose(standby_o) |-> cnt_reg >= STANDBY_CYC)
		else $error("standby early");
endmodule // hpx_ctrl_checker
bind hpx_ctrl hpx_ctrl_checker #(.STANDBY_CYC(STANDBY_CYC)) u_hpx_ctrl_checker (.*);

// file: sim/hpx_ctrl_tb.sv
// Self-checking bench for the plug detect and routing control block.
// Assumes a sink model on the pins; host settings driven directly.
`timescale 1ns/100ps
module hpx_ctrl_tb;
	logic clk = 0, rst = 1, rn = 0, plug = 0, tmds = 0, irq = 0, pin_p, pin_c;
	logic frc = 0, hp = 0, hc = 0, hv = 0, ovr = 0, td = 0, sp, sc, on, sd, sb, tm;
	logic [1:0] sel = 0;
	hpx_pkg::hpx_link_t hl = '0, lk;
	hpx_pkg::hpx_route_t rt;
	logic [9:0] q[$];
	logic [31:0] r;
	int errors = 0, n_checks = 0, seed = 11741, i;
	event ev;
	wire [9:0] obs = {sd, sb, on, sp, sc, rt};
	always #5 clk = ~clk;
	hpx_sink_model #(.IRQ_CYC(50)) u_hpx_sink_model (.sys_clk_i(clk), .plug_i(plug),
		.tmds_i(tmds), .irq_i(irq), .plug_o(pin_p), .cad_o(pin_c));
	// Short standby count keeps the run brief
	hpx_ctrl #(.STANDBY_CYC(400)) u_hpx_ctrl (.sys_clk_i(clk), .sys_rst_i(rst),
		.chip_reset_n_i(rn), .sink_plug_detect_in_i(pin_p), .sink_adapter_detect_in_i(pin_c),
		.source_plug_detect_out_o(sp), .source_adapter_detect_out_o(sc), .route_sel_i(sel),
		.host_force_i(frc), .host_plug_i(hp), .host_adapter_i(hc), .host_link_valid_i(hv),
		.host_link_i(hl), .host_drive_override_i(ovr), .training_done_i(td), .route_o(rt),
		.link_o(lk), .link_on_o(on), .shutdown_o(sd), .standby_o(sb), .tmds_mode_o(tm));
	function automatic logic [9:0] ex(logic p, logic c, logic [1:0] s, logic o);
		logic [4:0] e;
		e = !p ? {4'h0, c} : !c ? (s == 2'h1 ? 5'h12 : 5'h1a) : (s == 2'h0 ? 5'h15 : 5'h19);
		return {2'h0, o, p, c, e};
	endfunction
	task go(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task look(logic [9:0] e);
		q.push_back(e);
		->ev;
	endtask
	always @(ev)
	begin
		n_checks++;
		if (obs !== q[0])
		begin
			errors++;
			$display("BAD obs exp %h got %h", q[0], obs);
		end
		q.pop_front();
	end
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		go(3000);
		errors++;
		report_and_stop;
	end
	initial
	begin
		go(20);
		rst = 0;
		go(4);
		rn = 1;
		go(8);
		for (i = 0; i < 24; i++)
		begin
			r = $random(seed);
			{ovr, sel, tmds, plug} = r[4:0];
			hl = hpx_pkg::hpx_link_t'(19'($random(seed)));
			go(8);
			look(ex(plug, tmds, sel, 1'h0));
		end
		{sel, tmds, plug} = 4'h1;
		go(8);
		irq = 1;
		go(1);
		irq = 0;
		go(4);
		look(ex(1'h0, 1'h0, 2'h0, 1'h0));
		go(50);
		look(ex(1'h1, 1'h0, 2'h0, 1'h0));
		{frc, hp, hc, plug} = 4'he;
		ovr = 0;
		go(4);
		look(ex(1'h1, 1'h1, 2'h0, 1'h0));
		n_checks++;
		if ({tm, lk} !== {1'b1, 10'h258, 4'h0, 4'hf, 1'b0})
		begin
			errors++;
			$display("BAD link exp %h got %h", {1'b1, 10'h258, 4'h0, 4'hf, 1'b0}, {tm, lk});
		end
		frc = 0;
		go(380);
		look(ex(1'h0, 1'h0, 2'h0, 1'h0));
		go(30);
		look(ex(1'h0, 1'h0, 2'h0, 1'h0) | 10'h100);
		plug = 1;
		go(8);
		look(ex(1'h1, 1'h0, 2'h0, 1'h0));
		for (i = 0; i < 2; i++)
		begin
			{hv, td} = i ? 2'h2 : 2'h1;
			go(4);
			look(ex(1'h1, 1'h0, 2'h0, 1'h1));
			{hv, td, rn} = 3'h0;
			go(6);
			look(10'h240);
			rn = 1;
			go(10);
			look(ex(1'h1, 1'h0, 2'h0, 1'h0));
		end
		go(1);
		report_and_stop;
	end
endmodule // hpx_ctrl_tb

// file: sim/hpx_sink_model.sv
// Sink model: drives plug and adapter detect pins.
// Assumes one clock; pins move 1 ns after the edge.
`timescale 1ns/100ps
module hpx_sink_model #(
	parameter int IRQ_CYC = 50
) (
	input  wire logic sys_clk_i,
	input  wire logic plug_i,
	input  wire logic tmds_i,
	input  wire logic irq_i,
	output logic      plug_o = 1'h0,
	output logic      cad_o = 1'h0
);
	int n = 0;
	always @(posedge sys_clk_i)
	begin
		n <= irq_i ? IRQ_CYC : (n > 0 ? n - 1 : 0);
		plug_o <= #1 plug_i && !(irq_i || n > 1);
		cad_o <= #1 tmds_i;
	end
endmodule // hpx_sink_model
